//--- src/ascp_pkg.sv
// Shared constants and types of the ADC serial control port.
package ascp_pkg;

    // Serial word layout: four channel bits, then twelve result bits.
    localparam int FRAME_BITS = 16;
    localparam int CHAN_W = 4;
    localparam int DATA_W = 12;
    localparam int CTRL_W = 12;
    localparam int CNT_W = 5;
    localparam int NUM_CHAN = 16;

    // Control word field positions, first serial bit is bit 11.
    localparam int CTRL_WRITE = 11;
    localparam int CTRL_SEQ = 10;
    localparam int CTRL_ADDR_MSB = 9;
    localparam int CTRL_ADDR_LSB = 6;
    localparam int CTRL_SHADOW = 3;
    localparam int CTRL_RANGE = 1;
    localparam int CTRL_CODING = 0;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;
    localparam logic [NUM_CHAN-1:0] SHADOW_RESET = 16'h0000;

    // Result FIFO shape.
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = CHAN_W + DATA_W;
    localparam int LVL_W = 4;

    // Register byte offsets on the AHB-Lite slave.
    localparam logic [7:0] REG_CONFIG = 8'h00;
    localparam logic [7:0] REG_CONTROL = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_SHADOW = 8'h0C;

    // Field positions inside CONFIG and STATUS.
    localparam int CFG_ENABLE = 0;
    localparam logic CFG_ENABLE_RESET = 1'b1;
    localparam int STAT_ACTIVE = 0;
    localparam int STAT_UNDERRUN = 1;
    localparam int STAT_CHAN_LSB = 4;
    localparam int STAT_LVL_LSB = 8;
    localparam int STAT_PEND = 12;

    localparam logic [1:0] HRESP_OKAY = 2'h0;

    // Frame state of the serial side.
    typedef enum logic {
        FR_IDLE = 1'b0,
        FR_ACTIVE = 1'b1
    } ascp_frame_t;

endpackage : ascp_pkg

//--- src/ascp_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module ascp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8,
    parameter int LVL_W = 4
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out,
    output logic [LVL_W-1:0] level_out
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [LVL_W-1:0] level_q;
    logic push;
    logic pop;

    // Handshakes and honest full and empty flags.
    assign in_ready_out = (level_q != LVL_W'(DEPTH));
    assign out_valid_out = (level_q != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem[rd_ptr_q];
    assign level_out = level_q;

    // Pointer and level bookkeeping.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            level_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            level_q <= level_q + LVL_W'(push) - LVL_W'(pop);
        end
    end

    // Storage array, written only on an accepted push.
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data_in;
        end
    end

    a_fifo_no_overfill: assert property (@(posedge clk_in) disable iff (!rstn_in)
        level_q <= LVL_W'(DEPTH) && !(push && level_q == LVL_W'(DEPTH)))
        else $error("FIFO accepts data while full.");

    a_fifo_level_track: assert property (@(posedge clk_in) disable iff (!rstn_in)
        push && !pop |=> level_q == $past(level_q) + 1'b1)
        else $error("FIFO level did not rise after a push.");

endmodule : ascp_fifo

//--- src/ascp_port.sv
// Serial control and readout port of a sixteen-channel converter, with AHB-Lite registers.
`timescale 1ns/100ps
module ascp_port (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic sclk_in,
    input wire logic frame_sel_n_in,
    input wire logic din_in,
    output logic dout_out,
    output logic dout_oe_out,
    output logic conv_start_out,
    output logic conv_step_out,
    output logic [ascp_pkg::CHAN_W-1:0] conv_chan_out,
    output logic conv_range_out,
    input wire logic conv_valid_in,
    input wire logic [ascp_pkg::DATA_W-1:0] conv_data_in,
    input wire logic [ascp_pkg::CHAN_W-1:0] conv_chan_in,
    output logic conv_ready_out
);
    import ascp_pkg::*;

    // Pin synchronisers and edge history.
    logic sclk_s1_q, sclk_s2_q, sclk_prev_q;
    logic cs_s1_q, cs_s2_q, cs_prev_q;
    logic din_s1_q, din_s2_q;
    // Serial side state.
    ascp_frame_t state_q;
    logic [CNT_W-1:0] bit_cnt_q;
    logic [FRAME_BITS-1:0] din_sh_q;
    logic [FRAME_BITS-1:0] out_sh_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [NUM_CHAN-1:0] shadow_q;
    logic shadow_pend_q;
    logic [CHAN_W-1:0] cur_chan_q;
    logic seq_valid_q;
    logic dout_q, dout_oe_q, conv_start_q, conv_step_q, conv_range_q, conv_ready_q;
    // Register side state.
    logic cfg_en_q, underrun_q, wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;

    // Frame events seen on the synchronised pins.
    logic sclk_fall, cs_fall, cs_rise, frame_start, frame_end, in_frame, shift_evt, full_frame;
    assign sclk_fall = sclk_prev_q && !sclk_s2_q;
    assign cs_fall = cs_prev_q && !cs_s2_q;
    assign cs_rise = !cs_prev_q && cs_s2_q;
    assign in_frame = (state_q == FR_ACTIVE);
    assign frame_start = cs_fall && cfg_en_q && !in_frame;
    assign frame_end = in_frame && cs_rise;
    assign shift_evt = in_frame && sclk_fall && !cs_rise;
    assign full_frame = (bit_cnt_q == CNT_W'(FRAME_BITS));

    // Control word fields.
    logic ctl_seq, ctl_shadow, ctl_coding;
    logic [CHAN_W-1:0] ctl_addr;
    assign ctl_seq = ctrl_q[CTRL_SEQ];
    assign ctl_shadow = ctrl_q[CTRL_SHADOW];
    assign ctl_coding = ctrl_q[CTRL_CODING];
    assign ctl_addr = ctrl_q[CTRL_ADDR_MSB:CTRL_ADDR_LSB];

    // Next set bit of the sequence mask after a given channel, wrapping round.
    function automatic logic [CHAN_W-1:0] next_set(input logic [NUM_CHAN-1:0] mask,
                                                   input logic [CHAN_W-1:0] from);
        logic [CHAN_W-1:0] idx;
        logic found;
        logic [CHAN_W-1:0] res;
        res = from;
        found = 1'b0;
        for (int i = 1; i <= NUM_CHAN; i++) begin
            idx = from + i[CHAN_W-1:0];
            if (!found && mask[idx]) begin
                res = idx;
                found = 1'b1;
            end
        end
        return res;
    endfunction : next_set

    // Channel for the conversion that the next frame starts.
    logic [CHAN_W-1:0] seq_from, chan_shadow, chan_consec, next_chan;
    assign seq_from = seq_valid_q ? cur_chan_q : CHAN_W'(NUM_CHAN - 1);
    assign chan_shadow = (shadow_q == '0) ? ctl_addr : next_set(shadow_q, seq_from);
    assign chan_consec = (!seq_valid_q || cur_chan_q >= ctl_addr) ? '0 : cur_chan_q + 1'b1;
    assign next_chan = !ctl_seq ? ctl_addr : (ctl_shadow ? chan_consec : chan_shadow);

    // Result FIFO between converter and serial output.
    logic fifo_out_valid, fifo_in_ready, fifo_pop;
    logic [FIFO_WIDTH-1:0] fifo_head;
    logic [LVL_W-1:0] fifo_level;
    assign fifo_pop = frame_start;

    ascp_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH),
        .LVL_W(LVL_W)
    ) u_fifo (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .in_valid_in(conv_valid_in && conv_ready_q),
        .in_ready_out(fifo_in_ready),
        .in_data_in({conv_chan_in, conv_data_in}),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(fifo_pop),
        .out_data_out(fifo_head),
        .level_out(fifo_level)
    );

    // Outgoing word: channel, then the coded result; zero when no result waits.
    logic [DATA_W-1:0] head_data, coded_data;
    logic [FRAME_BITS-1:0] load_word;
    assign head_data = fifo_head[DATA_W-1:0];
    assign coded_data = ctl_coding ? {~head_data[DATA_W-1], head_data[DATA_W-2:0]}
        : head_data;
    assign load_word = fifo_out_valid ? {fifo_head[FIFO_WIDTH-1:DATA_W], coded_data}
        : '0;

    // Control update when a whole frame closes.
    logic [CTRL_W-1:0] din_ctrl;
    logic ctrl_wr, shadow_wr;
    assign din_ctrl = din_sh_q[FRAME_BITS-1:FRAME_BITS-CTRL_W];
    assign shadow_wr = frame_end && full_frame && shadow_pend_q;
    assign ctrl_wr = frame_end && full_frame && !shadow_pend_q && din_ctrl[CTRL_WRITE];

    // Two flip-flops on every pin, then one more on the clock and select pins for edge detection.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            {sclk_s1_q, sclk_s2_q, sclk_prev_q} <= 3'h0;
            {cs_s1_q, cs_s2_q, cs_prev_q} <= 3'h7;
            {din_s1_q, din_s2_q} <= 2'h0;
        end else begin
            {sclk_s1_q, sclk_s2_q, sclk_prev_q} <= {sclk_in, sclk_s1_q, sclk_s2_q};
            {cs_s1_q, cs_s2_q, cs_prev_q} <= {frame_sel_n_in, cs_s1_q, cs_s2_q};
            {din_s1_q, din_s2_q} <= {din_in, din_s1_q};
        end
    end

    // Frame state machine.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= FR_IDLE;
        end else begin
            case (state_q)
                FR_IDLE: state_q <= frame_start ? FR_ACTIVE : FR_IDLE;
                FR_ACTIVE: state_q <= cs_rise ? FR_IDLE : FR_ACTIVE;
                default: state_q <= FR_IDLE;
            endcase
        end
    end

    // Serial shifting in both directions.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bit_cnt_q <= '0;
            din_sh_q <= '0;
            out_sh_q <= '0;
            dout_q <= 1'b0;
        end else if (frame_start) begin
            bit_cnt_q <= '0;
            dout_q <= load_word[FRAME_BITS-1];
            out_sh_q <= {load_word[FRAME_BITS-2:0], 1'b0};
        end else if (shift_evt && !full_frame) begin
            bit_cnt_q <= bit_cnt_q + 1'b1;
            din_sh_q <= {din_sh_q[FRAME_BITS-2:0], din_s2_q};
            dout_q <= out_sh_q[FRAME_BITS-1];
            out_sh_q <= {out_sh_q[FRAME_BITS-2:0], 1'b0};
        end
    end

    // Output enable, conversion strobes and converter controls.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dout_oe_q <= 1'b0;
            conv_start_q <= 1'b0;
            conv_step_q <= 1'b0;
            conv_chan_out <= '0;
            conv_range_q <= 1'b0;
            conv_ready_q <= 1'b0;
        end else begin
            if (frame_start) begin
                dout_oe_q <= 1'b1;
            end else if (frame_end) begin
                dout_oe_q <= 1'b0;
            end
            conv_start_q <= frame_start;
            conv_step_q <= shift_evt;
            if (frame_start) begin
                conv_chan_out <= next_chan;
            end
            conv_range_q <= ctrl_q[CTRL_RANGE];
            conv_ready_q <= (fifo_level <= LVL_W'(FIFO_DEPTH - 2)) && fifo_in_ready;
        end
    end

    // Control word, sequence mask and sequencer position.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_q <= CTRL_RESET;
            shadow_q <= SHADOW_RESET;
            shadow_pend_q <= 1'b0;
            cur_chan_q <= '0;
            seq_valid_q <= 1'b0;
        end else begin
            if (shadow_wr) begin
                shadow_q <= din_sh_q;
                shadow_pend_q <= 1'b0;
                seq_valid_q <= 1'b0;
            end else if (ctrl_wr) begin
                ctrl_q <= din_ctrl;
                shadow_pend_q <= !din_ctrl[CTRL_SEQ] && din_ctrl[CTRL_SHADOW];
                seq_valid_q <= 1'b0;
            end else if (frame_start) begin
                cur_chan_q <= next_chan;
                seq_valid_q <= 1'b1;
            end
        end
    end

    // AHB-Lite decode and register read selection.
    logic addr_ok, rd_evt;
    logic [31:0] rd_mux, status_word;
    assign addr_ok = hsel_in && htrans_in[1] && hready_in;
    assign rd_evt = addr_ok && !hwrite_in;
    assign status_word = (32'(in_frame) << STAT_ACTIVE) | (32'(underrun_q) << STAT_UNDERRUN)
        | (32'(cur_chan_q) << STAT_CHAN_LSB) | (32'(fifo_level) << STAT_LVL_LSB)
        | (32'(shadow_pend_q) << STAT_PEND);
    assign rd_mux = (haddr_in[7:0] == REG_CONFIG) ? 32'(cfg_en_q) << CFG_ENABLE :
                    (haddr_in[7:0] == REG_CONTROL) ? 32'(ctrl_q) :
                    (haddr_in[7:0] == REG_STATUS) ? status_word :
                    (haddr_in[7:0] == REG_SHADOW) ? 32'(shadow_q) : 32'h0000_0000;

    // Bus slave: zero wait states, writes land at the end of the data phase.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            hrdata_q <= '0;
            hreadyout_q <= 1'b0;
            cfg_en_q <= CFG_ENABLE_RESET;
            underrun_q <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
            wr_pend_q <= addr_ok && hwrite_in;
            wr_addr_q <= haddr_in[7:0];
            if (rd_evt) begin
                hrdata_q <= rd_mux;
            end
            if (wr_pend_q && wr_addr_q == REG_CONFIG) begin
                cfg_en_q <= hwdata_in[CFG_ENABLE];
            end
            if (frame_start && !fifo_out_valid) begin
                underrun_q <= 1'b1;
            end else if (wr_pend_q && wr_addr_q == REG_STATUS && hwdata_in[STAT_UNDERRUN]) begin
                underrun_q <= 1'b0;
            end
        end
    end

    assign hrdata_out = hrdata_q;
    assign hreadyout_out = hreadyout_q;
    assign hresp_out = HRESP_OKAY[0];
    assign dout_out = dout_q;
    assign dout_oe_out = dout_oe_q;
    assign conv_start_out = conv_start_q;
    assign conv_step_out = conv_step_q;
    assign conv_range_out = conv_range_q;
    assign conv_ready_out = conv_ready_q;

    a_din_shift_in: assert property (@(posedge clk_in) disable iff (!rstn_in)
        shift_evt && !full_frame |=> din_sh_q[0] == $past(din_s2_q)
        && bit_cnt_q == $past(bit_cnt_q) + 1'b1)
        else $error("Serial input bit not taken on a falling clock edge.");

    a_dout_hold_steady: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !sclk_fall && !frame_start |=> $stable(dout_q))
        else $error("Serial output changed away from a falling edge.");

    a_frame_word_load: assert property (@(posedge clk_in) disable iff (!rstn_in)
        frame_start && fifo_out_valid |=> dout_q == $past(fifo_head[FIFO_WIDTH-1])
        && out_sh_q[FRAME_BITS-1 -: 3] == $past(fifo_head[FIFO_WIDTH-2 -: 3]))
        else $error("Frame did not open with the channel bits.");

    a_coding_msb_flip: assert property (@(posedge clk_in) disable iff (!rstn_in)
        frame_start && fifo_out_valid |=> out_sh_q[DATA_W]
        == ($past(fifo_head[DATA_W-1]) ^ $past(ctl_coding)))
        else $error("Result coding does not follow the coding bit.");

    a_chan_select_start: assert property (@(posedge clk_in) disable iff (!rstn_in)
        frame_start && !ctl_seq |=> conv_start_out && conv_chan_out == $past(ctl_addr))
        else $error("Addressed channel not selected at frame start.");

    a_range_follow_ctrl: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ctrl_wr |=> ##1 conv_range_out == $past(din_ctrl[CTRL_RANGE], 2))
        else $error("Range output does not follow the written range bit.");

    a_step_per_fall: assert property (@(posedge clk_in) disable iff (!rstn_in)
        in_frame && sclk_fall && !cs_rise |=> conv_step_out)
        else $error("Conversion step missing on a serial clock edge.");

    a_release_on_close: assert property (@(posedge clk_in) disable iff (!rstn_in)
        frame_end |=> !dout_oe_out [*2])
        else $error("Serial output still driven after the frame closed.");

endmodule : ascp_port

//--- dv/ascp_host_model.sv
// Serial host model that frames transfers, clocks the port and captures its output.
`timescale 1ns/100ps
module ascp_host_model #(
    parameter int HALF = 6
) (
    input wire logic clk_in,
    input wire logic sdo_in,
    output logic sclk_out,
    output logic frame_sel_n_out,
    output logic din_out
);
    int glitch_cnt = 0;
    logic in_frame = 1'b0;
    logic sdo_prev = 1'b0;

    // The serial clock stands high and the select is released outside frames.
    initial begin
        sclk_out = 1'b1;
        frame_sel_n_out = 1'b1;
        din_out = 1'b0;
    end

    // Counts output changes while the serial clock is high inside a frame.
    always @(negedge clk_in) begin
        if (in_frame && sclk_out && sdo_in !== sdo_prev) begin
            glitch_cnt++;
        end
        sdo_prev <= sdo_in;
    end

    // Runs one frame; each bit is set up before its falling edge and the output is read then.
    task automatic frame(input logic [15:0] tx, input int nfall, output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge clk_in);
        frame_sel_n_out <= 1'b0;
        repeat (8) @(posedge clk_in);
        in_frame = 1'b1;
        for (int i = 0; i < nfall; i++) begin
            din_out <= tx[15-i];
            repeat (HALF) @(posedge clk_in);
            rx[15-i] = sdo_in;
            sclk_out <= 1'b0;
            in_frame = (i < nfall - 1);
            repeat (HALF) @(posedge clk_in);
            sclk_out <= 1'b1;
        end
        repeat (HALF) @(posedge clk_in);
        frame_sel_n_out <= 1'b1;
        din_out <= ~din_out;
        repeat (12) @(posedge clk_in);
    endtask : frame
endmodule : ascp_host_model

//--- dv/test_ascp_port.sv
// Self-checking bench of the serial port with register, converter and serial traffic.
`timescale 1ns/100ps
module test_ascp_port;
    import ascp_pkg::*;
    localparam int LIMIT = 20000;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic conv_valid = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [3:0] cv_chan = 4'h0;
    logic [11:0] cv_data = 12'h000;
    logic sclk, fsel_n, din, coding, dout, dout_oe, hreadyout, hresp;
    logic conv_start, conv_step, conv_range, conv_ready;
    logic [31:0] hrdata, rd;
    logic [3:0] conv_chan, addr;
    logic [11:0] ctrl;
    logic [15:0] rx, exp_w;
    logic [15:0] fifo_q[$];
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    int starts, steps, oe_seen;
    int seed = 32'h11756FB2;
    wire logic sdo = dout_oe ? dout : 1'bz;

    // Free-running system clock.
    always #5 clk = ~clk;

    ascp_port u_ascp_port (
        .clk_in(clk), .rstn_in(rstn), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
        .hresp_out(hresp), .sclk_in(sclk), .frame_sel_n_in(fsel_n), .din_in(din),
        .dout_out(dout), .dout_oe_out(dout_oe), .conv_start_out(conv_start),
        .conv_step_out(conv_step), .conv_chan_out(conv_chan), .conv_range_out(conv_range),
        .conv_valid_in(conv_valid), .conv_data_in(cv_data), .conv_chan_in(cv_chan),
        .conv_ready_out(conv_ready)
    );

    ascp_host_model u_ascp_host_model (
        .clk_in(clk), .sdo_in(sdo), .sclk_out(sclk), .frame_sel_n_out(fsel_n),
        .din_out(din)
    );

    // Counts cycles and frame pulses, and cuts a hang short.
    always @(posedge clk) begin
        cycles++;
        starts += conv_start;
        steps += conv_step;
        oe_seen += dout_oe;
        if (cycles == LIMIT) begin
            err_total++;
            summarize();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize;
        if (err_total == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    // One single AHB-Lite transfer; the address phase is held until the slave is ready.
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdv);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask : ahb

    // Offers random results for twelve cycles, recording each accepted one.
    task automatic fill;
        logic [15:0] ent;
        ent = $random(seed);
        @(posedge clk);
        conv_valid <= 1'b1;
        {cv_chan, cv_data} <= ent;
        repeat (12) begin
            @(posedge clk);
            if (conv_ready === 1'b1) begin
                fifo_q.push_back(ent);
                ent = $random(seed);
                {cv_chan, cv_data} <= ent;
            end
        end
        conv_valid <= 1'b0;
    endtask : fill

    // Pops the oldest result and applies the coding in force at frame start.
    function automatic logic [15:0] next_word(input logic cod);
        logic [15:0] e;
        e = 16'h0000;
        if (fifo_q.size() > 0) begin
            e = fifo_q.pop_front();
            e[11] = e[11] ^ cod;
        end
        return e;
    endfunction : next_word

    function automatic logic [11:0] cword(input logic wr, sq, input logic [3:0] a,
                                          input logic sh, rng, cod);
        return {wr, sq, a, 2'b00, sh, 1'b0, rng, cod};
    endfunction : cword

    task automatic run_frame(input logic [15:0] tx, input int nfall);
        starts = 0;
        steps = 0;
        oe_seen = 0;
        u_ascp_host_model.frame(tx, nfall, rx);
    endtask : run_frame

    // Writes a sequence setup, then checks the channel picked at each following frame.
    task automatic walk(input logic [11:0] c, input logic [19:0] chans);
        run_frame({c, 4'h0}, 16);
        for (int i = 4; i >= 0; i--) begin
            run_frame(16'h0000, 16);
            check(conv_chan, chans[i*4 +: 4]);
        end
    endtask : walk

    // Main sequence: registers, buffer, frames, coding, underrun and sequencer.
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        ahb(1'b0, REG_CONFIG, 32'h0, rd);
        check(rd, {31'h0, CFG_ENABLE_RESET});
        ahb(1'b1, 8'h10, 32'hFFFFFFFF, rd);
        ahb(1'b0, 8'h10, 32'h0, rd);
        check({rd[31:1], hresp}, 32'h0);
        ahb(1'b1, REG_CONTROL, 32'hFFFFFFFF, rd);
        ahb(1'b0, REG_CONTROL, 32'h0, rd);
        check(rd, {20'h0, CTRL_RESET});
        fill();
        check(conv_ready, 1'b0);
        ahb(1'b0, REG_STATUS, 32'h0, rd);
        check(rd[11:8], fifo_q.size());
        coding = 1'b0;
        addr = $random(seed);
        ctrl = cword(1'b1, 1'b0, addr, 1'b0, 1'b1, 1'b1);
        run_frame({ctrl, 4'h0}, 16);
        check(rx, next_word(coding));
        check(starts, 1);
        check(steps, 16);
        check(dout_oe, 1'b0);
        ahb(1'b0, REG_CONTROL, 32'h0, rd);
        check(rd, {20'h0, ctrl});
        check(conv_range, 1'b1);
        coding = 1'b1;
        run_frame(16'h7FFF, 16);
        check(rx, next_word(coding));
        check(conv_chan, addr);
        run_frame(16'hF000, 10);
        exp_w = next_word(coding);
        check(rx[15:6], exp_w[15:6]);
        ahb(1'b0, REG_CONTROL, 32'h0, rd);
        check(rd, {20'h0, ctrl});
        ahb(1'b1, REG_CONFIG, 32'h0, rd);
        run_frame(16'hF000, 16);
        check(oe_seen, 0);
        ahb(1'b1, REG_CONFIG, 32'h1, rd);
        while (fifo_q.size() > 0) begin
            ctrl = $random(seed);
            ctrl = cword(1'b1, 1'b0, ctrl[9:6], 1'b0, ctrl[1], ctrl[0] & (fifo_q.size() > 1));
            run_frame({ctrl, 4'h0}, 16);
            check(rx, next_word(coding));
            check(conv_chan, addr);
            check(conv_range, ctrl[1]);
            addr = ctrl[9:6];
            coding = ctrl[0];
        end
        run_frame(16'h0000, 16);
        check(rx, 16'h0000);
        ahb(1'b0, REG_STATUS, 32'h0, rd);
        check(rd[STAT_UNDERRUN], 1'b1);
        ahb(1'b1, REG_STATUS, 32'h2, rd);
        ahb(1'b0, REG_STATUS, 32'h0, rd);
        check(rd[STAT_UNDERRUN], 1'b0);
        run_frame({cword(1'b1, 1'b0, 4'h0, 1'b1, 1'b0, 1'b0), 4'h0}, 16);
        run_frame(16'h8421, 16);
        ahb(1'b0, REG_SHADOW, 32'h0, rd);
        check(rd, 32'h8421);
        walk(cword(1'b1, 1'b1, 4'h0, 1'b0, 1'b0, 1'b0), 20'h05AF0);
        walk(cword(1'b1, 1'b1, 4'h2, 1'b1, 1'b0, 1'b0), 20'h01201);
        check(u_ascp_host_model.glitch_cnt, 0);
        summarize();
    end
endmodule : test_ascp_port
